//--- dv/serial_flash_powerup_mode_select_tb.sv
/*
  Bench for the power-up and mode select block.
  Assumes the host model in sfpms_host.sv.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_flash_powerup_mode_select_tb;
  import sfpms_pkg::*;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       por_n = 1'b0;
  logic       so_data = 1'b0;
  logic       so_req = 1'b0;
  logic       wr_cmd = 1'b0;
  wire        cs_n;
  wire        sck;
  wire        si;
  logic       so;
  logic       so_oe;
  logic       mode3;
  logic       write_ok;
  logic       cmd_valid;
  logic       wr_discard;
  logic       standby;
  logic [7:0] cmd_opcode;
  int         err_count = 0;
  int         checks_done = 0;
  int         nvalid = 0;
  int         noe = 0;
  // host wait after supply, value arbitrary
  localparam int SELECT_AFTER_SUPPLY_DELAY = 10;
  always #20 clk = ~clk;
  always @(posedge clk)
  begin
    if (cmd_valid === 1'b1)
      nvalid++;
    if (so_oe === 1'b1)
      noe++;
  end
  sfpms_host sfpms_host_i (.cs_n(cs_n), .sck(sck), .si(si));
  sfpms_top sfpms_top_i (.clk(clk), .rst_n(rst_n), .por_n(por_n), .cs_n(cs_n),
    .sck(sck), .si(si), .so_data(so_data), .so_req(so_req), .wr_cmd(wr_cmd),
    .so(so), .so_oe(so_oe), .mode3(mode3), .write_ok(write_ok),
    .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode), .wr_discard(wr_discard),
    .standby(standby));
  task automatic chk(string n, logic [7:0] e, logic [7:0] s);
    checks_done++;
    if (s !== e)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic t_por();
    @(posedge clk);
    so_req <= 1'b1;
    sfpms_host_i.send(1'b0, 8'hC3);
    chk("valid", 8'h00, 8'(nvalid));
    chk("oe_count", 8'h00, 8'(noe));
    chk("mode3", 8'h01, {7'h00, mode3});
    chk("so_oe", 8'h00, {7'h00, so_oe});
    chk("wok", 8'h00, {7'h00, write_ok});
  endtask
  task automatic t_mode(logic idle, logic [7:0] b, int n, logic req, logic d);
    int k;
    @(posedge clk);
    so_req  <= req;
    so_data <= d;
    k = noe;
    sfpms_host_i.send(idle, b);
    chk("oe_seen", {7'h00, req}, {7'h00, noe > k});
    if (req)
      chk("so", {7'h00, d}, {7'h00, so});
    chk("mode3", {7'h00, idle}, {7'h00, mode3});
    chk("opcode", b, cmd_opcode);
    chk("valid", 8'(n), 8'(nvalid));
    chk("stby", 8'h01, {7'h00, standby});
    chk("so_oe", 8'h00, {7'h00, so_oe});
  endtask
  task automatic t_wr();
    logic s;
    s = 1'b0;
    @(posedge clk) wr_cmd <= 1'b1;
    @(posedge clk) wr_cmd <= 1'b0;
    repeat (2)
    begin
      #1 s = s | wr_discard;
      @(posedge clk);
    end
    chk("discard", 8'h01, {7'h00, s});
    chk("wok", 8'h00, {7'h00, write_ok});
  endtask
  task automatic t_nosel(int n);
    sfpms_host_i.idle_clocks(8);
    #400;
    chk("valid", 8'(n), 8'(nvalid));
  endtask
  task automatic t_rst();
    @(posedge clk) rst_n <= 1'b0;
    @(posedge clk);
    #1 chk("mode3", 8'h01, {7'h00, mode3});
    chk("so_oe", 8'h00, {7'h00, so_oe});
    @(posedge clk) rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("stby", 8'h01, {7'h00, standby});
    chk("mode3", 8'h01, {7'h00, mode3});
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1 chk("mode3", 8'h01, {7'h00, mode3});
    chk("so_oe", 8'h00, {7'h00, so_oe});
    t_por();
    @(posedge clk) por_n <= 1'b1;
    // select only after the supply wait
    repeat (SELECT_AFTER_SUPPLY_DELAY) @(posedge clk);
    t_mode(1'b0, 8'hA5, 1, 1'b1, 1'b1);
    t_mode(1'b1, 8'h5A, 2, 1'b1, 1'b0);
    t_mode(1'b0, 8'h01, 3, 1'b0, 1'b1);
    t_nosel(3);
    t_wr();
    t_rst();
    results();
  end
endmodule
`default_nettype wire

//--- dv/sfpms_host.sv
/*
  Host serial controller model: drives select, clock and data in.
  Assumes the bench calls send once per instruction.
*/
`timescale 1ns/1ps
`default_nettype none
module sfpms_host
(
  output var logic cs_n,
  output var logic sck,
  output var logic si
);
  initial
  begin
    cs_n = 1'b1;
    sck  = 1'b1;
    si   = 1'b1;
  end
  // idle level, select fall, MSB first
  task automatic send(input logic idle, input logic [7:0] b);
    int i;
    #5 sck = idle;
    #400 cs_n = 1'b0;
    for (i = 7; i >= 0; i--)
    begin
      #160 sck = 1'b0;
      si = b[i];
      #160 sck = 1'b1;
    end
    #160 sck = idle;
    cs_n = 1'b1;
    si = ~si;
    #400;
  endtask
  task automatic idle_clocks(input int n);
    int i;
    for (i = 0; i < n; i++)
    begin
      #165 sck = 1'b0;
      #155 sck = 1'b1;
    end
  endtask
endmodule
`default_nettype wire

//--- rtl/sfpms_pkg.sv
/*
  Package for the serial flash power-up and mode select block.
  Assumes a 25 MHz system clock.
*/
package sfpms_pkg;
  localparam int unsigned CLK_HZ                  = 25000000;
  localparam int unsigned WRITE_PERMIT_DELAY_MS   = 20;
  localparam int unsigned WRITE_PERMIT_CYCLES     =
    (CLK_HZ / 1000) * WRITE_PERMIT_DELAY_MS;
  localparam int unsigned WP_CNT_W                = 20;
  localparam logic [7:0]  OPC_RESET_VAL           = 8'h00;
  localparam logic [2:0]  BIT_CNT_RESET_VAL       = 3'h0;
  localparam logic        MODE_DEFAULT            = 1'b1;
  localparam int unsigned SYNC_STAGES             = 3;
  typedef enum logic [1:0]
  {
    SFPMS_POR     = 2'b00,
    SFPMS_STANDBY = 2'b01,
    SFPMS_ACTIVE  = 2'b10
  } sfpms_pwr_t;
  typedef enum logic
  {
    SFPMS_MODE0 = 1'b0,
    SFPMS_MODE3 = 1'b1
  } sfpms_mode_t;
endpackage

//--- rtl/sfpms_sync.sv
/*
  Three-stage pin synchroniser with edge detection.
  Assumes an asynchronous pin and a free-running clk.
*/
`timescale 1ns/1ps
`default_nettype none
module sfpms_sync
  import sfpms_pkg::*;
#(
  parameter logic RST_VAL = 1'b0
)
(
  input  wire logic    clk,
  input  wire logic    rst_n,
  input  wire logic    pin,
  sfpms_sync_if.src    sync
);
  logic [2:0] sh_r;
  logic       lvl_r;
  wire        agree = (sh_r[1] == sh_r[2]);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sh_r  <= {3{RST_VAL}};
      lvl_r <= RST_VAL;
    end
    else
    begin
      sh_r <= {sh_r[1:0], pin};
      if (agree)
        lvl_r <= sh_r[2];
    end
  end
  assign sync.level = lvl_r;
  assign sync.rise  = agree && sh_r[2] && !lvl_r;
  assign sync.fall  = agree && !sh_r[2] && lvl_r;
endmodule
`default_nettype wire

//--- rtl/sfpms_sync_if.sv
/*
  Interface carrying synchronised pin levels and edge pulses.
  Assumes one clock domain, clk.
*/
`timescale 1ns/1ps
`default_nettype none
interface sfpms_sync_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface
`default_nettype wire

//--- rtl/sfpms_top.sv
/*
  Power-on state, mode select and command gating of a serial flash.
  Assumes por_n from an internal supply monitor; host drives cs, sck, si.
*/
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Default mode 3 after power-up or reset
// - Data output undriven after reset
// - Instruction starts only on select falling edge
// - Sample clock idle level at select fall
// - Ignore all commands during power-on reset
// - Refuse program/erase until permit delay ends
// - Rest in standby after power-up
// - Clock low means mode 0, high mode 3
// - Shift out on falling, capture on rising
module sfpms_top
  import sfpms_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic por_n,
  input  wire logic cs_n,
  input  wire logic sck,
  input  wire logic si,
  input  wire logic so_data,
  input  wire logic so_req,
  input  wire logic wr_cmd,
  output logic      so,
  output logic      so_oe,
  output logic      mode3,
  output logic      write_ok,
  output logic      cmd_valid,
  output logic [7:0] cmd_opcode,
  output logic      wr_discard,
  output logic      standby
);
  sfpms_sync_if cs_s ();
  sfpms_sync_if ck_s ();
  sfpms_sync_if si_s ();
  sfpms_pwr_t   pwr_r, pwr_nxt;
  logic [WP_CNT_W-1:0] wp_cnt_r;
  logic [2:0]   bit_cnt_r;
  logic [7:0]   sh_r;
  logic         mode3_r, so_r, so_oe_r, wok_r, cv_r, disc_r, armed_r, first_r, stby_r;
  logic [7:0]   opc_r;

  sfpms_sync #(.RST_VAL(1'b1)) u_cs
  (
    .clk   (clk),
    .rst_n (rst_n),
    .pin   (cs_n),
    .sync  (cs_s)
  );
  sfpms_sync #(.RST_VAL(1'b1)) u_ck
  (
    .clk   (clk),
    .rst_n (rst_n),
    .pin   (sck),
    .sync  (ck_s)
  );
  // Data in is a pin too, delayed like the clock
  sfpms_sync #(.RST_VAL(1'b1)) u_si
  (
    .clk   (clk),
    .rst_n (rst_n),
    .pin   (si),
    .sync  (si_s)
  );

  wire        por_act   = !por_n;
  wire        sel       = !cs_s.level && armed_r;
  wire        cap       = sel && ck_s.rise;
  wire        shift_out = sel && ck_s.fall;
  wire        byte_done = cap && (bit_cnt_r == 3'h7);
  wire [7:0]  byte_val  = {sh_r[6:0], si_s.level};
  wire        wp_done   = (wp_cnt_r == WP_CNT_W'(WRITE_PERMIT_CYCLES));

  always_comb
  begin
    pwr_nxt = pwr_r;
    unique case (pwr_r)
      SFPMS_POR:     pwr_nxt = por_act ? SFPMS_POR : SFPMS_STANDBY;
      SFPMS_STANDBY: pwr_nxt = por_act ? SFPMS_POR : (sel ? SFPMS_ACTIVE : SFPMS_STANDBY);
      SFPMS_ACTIVE:  pwr_nxt = por_act ? SFPMS_POR : (sel ? SFPMS_ACTIVE : SFPMS_STANDBY);
      default:       pwr_nxt = SFPMS_POR;
    endcase
  end
  wire        to_stby   = (pwr_nxt == SFPMS_STANDBY);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pwr_r  <= SFPMS_POR;
      stby_r <= 1'b0;
    end
    else
    begin
      pwr_r  <= pwr_nxt;
      stby_r <= to_stby;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      wp_cnt_r <= '0;
    else if (por_act)
      wp_cnt_r <= '0;
    else if (!wp_done)
      wp_cnt_r <= wp_cnt_r + 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      mode3_r <= MODE_DEFAULT;
    else if (por_act)
      mode3_r <= MODE_DEFAULT;
    else if (cs_s.fall)
      mode3_r <= ck_s.level;
  end

  // arm only on select falling edge
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      armed_r <= 1'b0;
    else if (por_act || cs_s.rise)
      armed_r <= 1'b0;
    else if (cs_s.fall)
      armed_r <= 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sh_r      <= OPC_RESET_VAL;
      bit_cnt_r <= BIT_CNT_RESET_VAL;
      first_r   <= 1'b0;
    end
    else if (!sel)
    begin
      bit_cnt_r <= BIT_CNT_RESET_VAL;
      first_r   <= 1'b1;
    end
    else if (cap)
    begin
      sh_r      <= byte_val;
      bit_cnt_r <= bit_cnt_r + 1'b1;
      if (byte_done)
        first_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cv_r   <= 1'b0;
      opc_r  <= OPC_RESET_VAL;
      disc_r <= 1'b0;
      wok_r  <= 1'b0;
    end
    else
    begin
      cv_r   <= byte_done && first_r && !por_act;
      disc_r <= wr_cmd && !wp_done;
      wok_r  <= wp_done && !por_act;
      if (byte_done && first_r)
        opc_r <= byte_val;
    end
  end

  // output undriven until selected and requested
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      so_r    <= 1'b0;
      so_oe_r <= 1'b0;
    end
    else
    begin
      so_oe_r <= sel && so_req && !por_act;
      if (shift_out)
        so_r <= so_data;
    end
  end

  assign so         = so_r;
  assign so_oe      = so_oe_r;
  assign mode3      = mode3_r;
  assign write_ok   = wok_r;
  assign cmd_valid  = cv_r;
  assign cmd_opcode = opc_r;
  assign wr_discard = disc_r;
  assign standby    = stby_r;

  write_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    write_ok |-> $past(wp_done));
  so_undriven_a: assert property (@(posedge clk) disable iff (!rst_n)
    so_oe |-> $past(sel));
  por_block_a: assert property (@(posedge clk) disable iff (!rst_n)
    $past(por_act) |-> !cmd_valid && !so_oe);
  // mode follows clock level at select fall
  mode_pick_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cs_s.fall && !por_act) |=> (mode3 == $past(ck_s.level)));
  early_wr_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_cmd && !wp_done) |=> wr_discard);
  // arming only after a select fall
  arm_cause_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(armed_r) |-> $past(cs_s.fall));
  // standby after reset ends and idle
  idle_standby_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!por_act && !sel) ##1 (!por_act && !sel) |=> standby);
  default_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
    $past(por_act) |-> mode3);
endmodule
`default_nettype wire
